// [pkg/wcd_cfg.svh]
// wiper command decoder: register offsets, status fields, resets, timing
// assumes one 200 MHz clock and an axi4-lite word-aligned register bus
`ifndef WCD_CFG_SVH
`define WCD_CFG_SVH

`define WCD_OFF_CMD 8'h00
`define WCD_OFF_RDBK 8'h04
`define WCD_OFF_STAT 8'h08
`define WCD_OFF_WIPE 8'h0c

`define WCD_ST_BUSY 0
`define WCD_ST_LIN 1
`define WCD_ST_SHDN 2
`define WCD_ST_TOP 3
`define WCD_ST_BOT 4
`define WCD_ST_CTRL 8
`define WCD_RB_VALID 8

`define WCD_NVM_RST 8'h80
`define WCD_CTRL_RST 4'h0

`define WCD_RESP_OKAY 2'b00
`define WCD_RESP_SLVERR 2'b10
`define WCD_RESP_DECERR 2'b11

`define WCD_SRST_NS 30000
`define WCD_CLK_MHZ 200

`endif

// [pkg/wcd_pkg.sv]
// wiper command decoder: command codes, sequencer states, step kinds
// assumes nothing beyond the command word layout
package wcd_pkg;
   typedef enum logic [3:0] {
      WCD_NOP = 4'h0, WCD_WR_WIPER = 4'h1, WCD_WR_INPUT = 4'h2,
      WCD_READBACK = 4'h3, WCD_STEP = 4'h4, WCD_SHIFT = 4'h5,
      WCD_LOAD = 4'h6, WCD_COPY = 4'h7, WCD_WR_NVM = 4'h8,
      WCD_SCALE = 4'h9, WCD_SRST = 4'hb, WCD_SHUTDOWN = 4'hc,
      WCD_WR_CTRL = 4'hd
   } wcd_cmd_e;

   typedef enum logic [2:0] {
      WCD_ST_INIT = 3'b001,
      WCD_ST_IDLE = 3'b010,
      WCD_ST_RESET = 3'b100
   } wcd_state_e;

   typedef enum logic [1:0] {
      WCD_INC = 2'h0, WCD_DEC = 2'h1, WCD_DBL = 2'h2, WCD_HALF = 2'h3
   } wcd_step_e;
endpackage

// [pkg/wcd_reg_if.sv]
// register access between the bus slave and the command core
// assumes the slave drives strobes and the core answers in the same cycle
`timescale 1ns/100ps
interface wcd_reg_if #(parameter int ADDR_W = 8);
   logic wr_en;
   logic [ADDR_W-1:0] wr_addr;
   logic [31:0] wr_data;
   logic [3:0] wr_strb;
   logic [1:0] wr_resp;
   logic rd_en;
   logic [ADDR_W-1:0] rd_addr;
   logic [31:0] rd_data;
   logic [1:0] rd_resp;
   modport bus (output wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
      input wr_resp, rd_data, rd_resp);
   modport core (input wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
      output wr_resp, rd_data, rd_resp);
endinterface // wcd_reg_if

// [rtl/wcd_axil.sv]
// axi4-lite slave front end for the command decoder registers
// assumes the core answers strobes combinationally through the interface
`timescale 1ns/100ps
module wcd_axil #(parameter int ADDR_W = 8) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   wcd_reg_if.bus rif
);
   logic aw_full_q, w_full_q;
   logic [ADDR_W-1:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;

   // address and data held apart so either may come first
   assign s_axi_awready = ~aw_full_q;
   assign s_axi_wready = ~w_full_q;
   assign s_axi_arready = ~s_axi_rvalid;
   wire do_wr = aw_full_q & w_full_q & ~s_axi_bvalid;
   assign rif.wr_en = do_wr;
   assign rif.wr_addr = awaddr_q;
   assign rif.wr_data = wdata_q;
   assign rif.wr_strb = wstrb_q;
   assign rif.rd_en = s_axi_arvalid & ~s_axi_rvalid;
   assign rif.rd_addr = s_axi_araddr;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_full_q <= 1'b0;
         w_full_q <= 1'b0;
         awaddr_q <= '0;
         wdata_q <= '0;
         wstrb_q <= '0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'h0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= 2'h0;
      end else begin
         if (s_axi_awvalid && !aw_full_q) begin
            aw_full_q <= 1'b1;
            awaddr_q <= s_axi_awaddr;
         end else if (do_wr) begin
            aw_full_q <= 1'b0;
         end
         if (s_axi_wvalid && !w_full_q) begin
            w_full_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
         end else if (do_wr) begin
            w_full_q <= 1'b0;
         end
         if (do_wr) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= rif.wr_resp;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         if (rif.rd_en) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rif.rd_data;
            s_axi_rresp <= rif.rd_resp;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end
endmodule // wcd_axil

// [rtl/wcd_step.sv]
// one wiper step: linear up/down and doubling/halving
// assumes an unsigned wiper code of W bits
`timescale 1ns/100ps
module wcd_step import wcd_pkg::*; #(parameter int W = 8) (
   input wire logic [W-1:0] value,
   input wire wcd_step_e op,
   output logic [W-1:0] result
);
   wire at_top = &value;
   wire at_zero = ~|value;
   wire [W-1:0] one = {{(W-1){1'b0}}, 1'b1};
   wire [W-1:0] dbl = at_zero ? one : (value[W-1] ? '1 : value << 1);
   wire [W-1:0] inc = at_top ? value : value + one;
   wire [W-1:0] dec = at_zero ? value : value - one;

   always_comb begin
      unique case (op)
         WCD_INC: result = inc;
         WCD_DEC: result = dec;
         WCD_DBL: result = dbl;
         WCD_HALF: result = value >> 1;
      endcase
   end
endmodule // wcd_step

// [rtl/wcd_top.sv]
// wiper command decoder: executes 16-bit command words written by software
// assumes a synchronous active-low reset, pins synchronous to aclk
//
// Behaviour
// - word is code[15:12], address[11:8], data[7:0]; code zero does nothing.
// - input register tracks the wiper unless written by the input write.
// - code 0110 copies input to wiper for addressed or all channels.
// - active load pin copies every input register into its wiper.
// - load pin is ignored while a command executes.
// - independent pin sampled after reset; both strings load from memory.
// - linear gain mode is independent pin OR control bit D2.
// - readback D1:D0 picks input, memory, control or wiper.
// - code 0100 steps wiper up for D0=1, down for D0=0.
// - code 0101 doubles for D0=1, halves for D0=0; A3 means all.
// - doubling with top bit set gives all ones; halving zero stays zero.
// - code 1001 enters or leaves top or bottom scale, wiper kept.
// - code 1100 enters shutdown for D0=1, leaves for D0=0.
// - code 1011 reloads every wiper from memory over about 30 us.
// - in linear mode A3 all channels and A2 the second string; outside it the second string is never addressed; memory locations 0-3.
//
// The AXI4-Lite register port and the placing of the registers were decided locally.
`timescale 1ns/100ps
`include "wcd_cfg.svh"
module wcd_top import wcd_pkg::*; #(
   parameter int W = 8,
   parameter int ADDR_W = 8,
   parameter int SRST_CYCLES =
      (`WCD_SRST_NS * `WCD_CLK_MHZ + 999) / 1000
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic load_wiper_strobe_n,
   input wire logic independent_strings_pin,
   output logic [W-1:0] wiper_wb_level,
   output logic [W-1:0] wiper_aw_level,
   output logic shutdown_active,
   output logic linear_mode_active
);
   localparam int NCH = 2;
   localparam int NNVM = 4;
   localparam int CW = $clog2(SRST_CYCLES + 1);
   localparam logic [CW-1:0] SRST_LAST = CW'(SRST_CYCLES - 1);

   wcd_reg_if #(.ADDR_W(ADDR_W)) rif ();

   wcd_axil #(.ADDR_W(ADDR_W)) u_axil (
      .aclk(aclk),
      .aresetn(aresetn),
      .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready),
      .rif(rif.bus)
   );

   // state
   wcd_state_e state_q, state_d;
   logic [CW-1:0] cnt_q, cnt_d;
   logic [W-1:0] wiper_q [NCH];
   logic [W-1:0] wiper_d [NCH];
   logic [W-1:0] input_q [NCH];
   logic [W-1:0] input_d [NCH];
   logic [W-1:0] nvm_q [NNVM];
   logic [W-1:0] nvm_d [NNVM];
   logic [NCH-1:0] wiper_ld;
   logic [15:0] cmd_q;
   logic [3:0] ctrl_q;
   logic independent_strings_pin_q;
   logic top_q, bot_q, shdn_q;
   logic [W-1:0] rdbk_q;
   logic rdbk_vld_q;
   logic [W-1:0] level_q [NCH];

   function automatic logic [W-1:0] scaled(input logic [W-1:0] v,
         input logic top, input logic bot);
      scaled = top ? '1 : (bot ? '0 : v);
   endfunction

   // command word fields
   wire [3:0] code_raw = rif.wr_data[15:12];
   wcd_cmd_e code;
   assign code = wcd_cmd_e'(code_raw);
   wire [3:0] addr = rif.wr_data[11:8];
   wire [W-1:0] data = rif.wr_data[W-1:0];
   wire d0 = rif.wr_data[0];

   wire idle = (state_q == WCD_ST_IDLE);
   wire init = (state_q == WCD_ST_INIT);
   wire srst_done = (state_q == WCD_ST_RESET) && (cnt_q == SRST_LAST);
   wire lin = independent_strings_pin_q | ctrl_q[2];

   // bus decode
   wire wr_cmd = rif.wr_en && (rif.wr_addr == `WCD_OFF_CMD);
   wire strb_ok = &rif.wr_strb[1:0];
   wire exec = wr_cmd && idle && strb_ok;
   wire wr_ro = (rif.wr_addr == `WCD_OFF_RDBK) ||
      (rif.wr_addr == `WCD_OFF_STAT) || (rif.wr_addr == `WCD_OFF_WIPE);
   assign rif.wr_resp = (wr_cmd && exec) ? `WCD_RESP_OKAY :
      ((wr_cmd || wr_ro) ? `WCD_RESP_SLVERR : `WCD_RESP_DECERR);

   // channel and memory selection
   wire [NCH-1:0] sel;
   assign sel[0] = addr[3] | ~addr[2];
   assign sel[1] = lin & (addr[3] | addr[2]);
   wire rb_ch = addr[2] & lin;
   wire [1:0] nvm_loc = addr[2] ? 2'h1 : addr[1:0];

   // hardware load: level acts only when no command is being taken
   wire hw_ld = ~load_wiper_strobe_n & idle & ~exec;

   wcd_step_e step_op;
   assign step_op = (code == WCD_STEP) ? (d0 ? WCD_INC : WCD_DEC) :
      (d0 ? WCD_DBL : WCD_HALF);

   genvar c;
   generate
      for (c = 0; c < NCH; c++) begin : g_ch
         logic [W-1:0] step_res;
         wire hit = exec && sel[c];

         wcd_step #(.W(W)) u_step (
            .value(wiper_q[c]),
            .op(step_op),
            .result(step_res)
         );

         always_comb begin
            wiper_d[c] = wiper_q[c];
            input_d[c] = input_q[c];
            wiper_ld[c] = 1'b0;
            if (init || srst_done) begin
               wiper_d[c] = nvm_q[c];
               wiper_ld[c] = 1'b1;
            end else if (hit) begin
               unique case (code)
                  WCD_WR_WIPER: begin
                     wiper_d[c] = data;
                     wiper_ld[c] = 1'b1;
                  end
                  WCD_WR_INPUT: input_d[c] = data;
                  WCD_STEP, WCD_SHIFT: begin
                     wiper_d[c] = step_res;
                     wiper_ld[c] = 1'b1;
                  end
                  WCD_LOAD: begin
                     wiper_d[c] = input_q[c];
                     wiper_ld[c] = 1'b1;
                  end
                  WCD_COPY: begin
                     if (!d0) begin
                        wiper_d[c] = nvm_q[c];
                        wiper_ld[c] = 1'b1;
                     end
                  end
                  default: ;
               endcase
            end else if (hw_ld) begin
               wiper_d[c] = input_q[c];
               wiper_ld[c] = 1'b1;
            end
            // any wiper load drags the input register along
            if (wiper_ld[c]) begin
               input_d[c] = wiper_d[c];
            end
         end

         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               wiper_q[c] <= `WCD_NVM_RST;
               input_q[c] <= `WCD_NVM_RST;
               level_q[c] <= '0;
            end else begin
               wiper_q[c] <= wiper_d[c];
               input_q[c] <= input_d[c];
               level_q[c] <= scaled(wiper_q[c], top_q, bot_q);
            end
         end
      end
   endgenerate

   // nonvolatile store, modelled as flops reset to midscale
   always_comb begin
      for (int i = 0; i < NNVM; i++) begin
         nvm_d[i] = nvm_q[i];
      end
      if (exec && code == WCD_WR_NVM) begin
         nvm_d[nvm_loc] = data;
      end
      if (exec && code == WCD_COPY && d0) begin
         for (int i = 0; i < NCH; i++) begin
            if (sel[i]) begin
               nvm_d[i] = wiper_q[i];
            end
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         for (int i = 0; i < NNVM; i++) begin
            nvm_q[i] <= `WCD_NVM_RST;
         end
      end else begin
         nvm_q <= nvm_d;
      end
   end

   // sequencer: startup load, idle, software reset wait
   always_comb begin
      state_d = state_q;
      cnt_d = cnt_q;
      unique case (state_q)
         WCD_ST_INIT: state_d = WCD_ST_IDLE;
         WCD_ST_IDLE: begin
            if (exec && code == WCD_SRST) begin
               state_d = WCD_ST_RESET;
               cnt_d = '0;
            end
         end
         WCD_ST_RESET: begin
            if (srst_done) begin
               state_d = WCD_ST_IDLE;
            end else begin
               cnt_d = cnt_q + CW'(1);
            end
         end
         default: state_d = WCD_ST_INIT;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_q <= WCD_ST_INIT;
         cnt_q <= '0;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
      end
   end

   // pin is caught after release, not in reset
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         independent_strings_pin_q <= 1'b0;
      end else if (init) begin
         independent_strings_pin_q <= independent_strings_pin;
      end
   end

   // scale, shutdown and control flags
   wire scale_cmd = exec && code == WCD_SCALE;
   wire shdn_cmd = exec && code == WCD_SHUTDOWN;
   wire scale_exit = |wiper_ld || shdn_cmd;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         top_q <= 1'b0;
         bot_q <= 1'b0;
         shdn_q <= 1'b0;
         ctrl_q <= `WCD_CTRL_RST;
         cmd_q <= 16'h0;
      end else begin
         if (scale_cmd) begin
            top_q <= rif.wr_data[7] & d0;
            bot_q <= ~rif.wr_data[7] & d0;
         end else if (scale_exit) begin
            top_q <= 1'b0;
            bot_q <= 1'b0;
         end
         if (shdn_cmd) begin
            shdn_q <= d0;
         end
         if (exec && code == WCD_WR_CTRL) begin
            ctrl_q <= rif.wr_data[3:0];
         end
         if (exec) begin
            cmd_q <= rif.wr_data[15:0];
         end
      end
   end

   // readback source selection
   logic [W-1:0] rb_src;
   always_comb begin
      unique case (rif.wr_data[1:0])
         2'h0: rb_src = input_q[rb_ch];
         2'h1: rb_src = nvm_q[nvm_loc];
         2'h2: rb_src = W'(ctrl_q);
         2'h3: rb_src = wiper_q[rb_ch];
      endcase
   end

   wire rd_rdbk = rif.rd_en && (rif.rd_addr == `WCD_OFF_RDBK);
   wire rb_set = exec && code == WCD_READBACK;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rdbk_q <= '0;
         rdbk_vld_q <= 1'b0;
      end else begin
         if (rb_set) begin
            rdbk_q <= rb_src;
         end
         // a readback set beats a read clear
         rdbk_vld_q <= rb_set | (rdbk_vld_q & ~rd_rdbk);
      end
   end

   // register read mux
   logic [31:0] stat_w;
   logic [31:0] rdbk_w;
   always_comb begin
      stat_w = 32'h0;
      stat_w[`WCD_ST_BUSY] = ~idle;
      stat_w[`WCD_ST_LIN] = lin;
      stat_w[`WCD_ST_SHDN] = shdn_q;
      stat_w[`WCD_ST_TOP] = top_q;
      stat_w[`WCD_ST_BOT] = bot_q;
      stat_w[`WCD_ST_CTRL +: 4] = ctrl_q;
      rdbk_w = 32'h0;
      rdbk_w[W-1:0] = rdbk_q;
      rdbk_w[`WCD_RB_VALID] = rdbk_vld_q;
   end

   wire rd_cmd = rif.rd_addr == `WCD_OFF_CMD;
   wire rd_rb = rif.rd_addr == `WCD_OFF_RDBK;
   wire rd_st = rif.rd_addr == `WCD_OFF_STAT;
   wire rd_wp = rif.rd_addr == `WCD_OFF_WIPE;
   wire [31:0] wipe_w = 32'({wiper_q[1], wiper_q[0]});
   assign rif.rd_data = rd_cmd ? {16'h0, cmd_q} :
      rd_rb ? rdbk_w :
      rd_st ? stat_w :
      rd_wp ? wipe_w : 32'h0;
   assign rif.rd_resp = (rd_cmd | rd_rb | rd_st | rd_wp) ?
      `WCD_RESP_OKAY : `WCD_RESP_DECERR;

   // outputs come straight from flops, except linear_mode_active, which ORs two flops
   assign wiper_wb_level = level_q[0];
   assign wiper_aw_level = level_q[1];
   assign shutdown_active = shdn_q;
   assign linear_mode_active = independent_strings_pin_q | ctrl_q[2];
endmodule // wcd_top

// [testbench/test_wiper_command_decoder.sv]
// self-checking bench for the wiper command decoder
// assumes the host model drives the register bus, one 200 MHz clock
`timescale 1ns/100ps
`include "wcd_cfg.svh"
module test_wiper_command_decoder;
   logic aclk, aresetn, load_wiper_strobe_n, independent_strings_pin;
   logic [7:0] s_axi_awaddr, s_axi_araddr, wiper_wb_level, wiper_aw_level;
   logic [31:0] s_axi_wdata, s_axi_rdata, d;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, r;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic s_axi_rvalid, s_axi_rready, shutdown_active, linear_mode_active;
   int err_total = 0;
   int n_checks = 0;
   // start value, command word, expected level
   logic [31:0] tbl [11] = '{32'h44400145, 32'hff4001ff, 32'h00400000,
      32'h45400044, 32'h21500142, 32'h815001ff, 32'h00500101,
      32'h42500021, 32'h00500000, 32'h80480181, 32'h01580000};

   wcd_top #(.SRST_CYCLES(8)) dut (.*);
   wcd_host host (.*);

   initial begin
      aclk = 1'b0;
      forever #2.5 aclk = ~aclk;
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic end_sim;
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic rst(input logic pin);
      aresetn <= 1'b0;
      independent_strings_pin <= pin;
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (4) @(posedge aclk);
   endtask
   // level lags the wiper by a clock
   task automatic cmd(input logic [15:0] w);
      host.wr(`WCD_OFF_CMD, w, 4'hf, r);
      chk(32'(r), 32'(`WCD_RESP_OKAY));
      repeat (2) @(posedge aclk);
   endtask
   task automatic lv(input logic [7:0] e);
      chk(32'(wiper_wb_level), 32'(e));
   endtask
   task automatic rb(input logic [15:0] w, input logic [7:0] e);
      cmd(w);
      host.rd(`WCD_OFF_RDBK, d, r);
      chk(d & 32'h1ff, {23'h0, 1'b1, e});
   endtask

   initial begin
      aresetn = 1'b0;
      load_wiper_strobe_n = 1'b1;
      independent_strings_pin = 1'b0;
      @(posedge aclk);
      rst(1'b0);
      lv(8'h80);
      chk(32'(linear_mode_active), 32'h0);
      host.rd(`WCD_OFF_STAT, d, r);
      chk(d & 32'hf1f, 32'h0);
      $display("test reset done");
      cmd(16'h105a);
      lv(8'h5a);
      cmd(16'h2033);
      lv(8'h5a);
      rb(16'h3000, 8'h33);
      rb(16'h3003, 8'h5a);
      rb(16'h3001, 8'h80);
      cmd(16'h6000);
      lv(8'h33);
      cmd(16'h0fff);
      lv(8'h33);
      cmd(16'h1044);
      cmd(16'h6000);
      lv(8'h44);
      $display("test write and load done");
      foreach (tbl[i]) begin
         cmd({8'h10, tbl[i][31:24]});
         cmd(tbl[i][23:8]);
         lv(tbl[i][7:0]);
      end
      $display("test steps done");
      cmd(16'h1066);
      cmd(16'h7001);
      cmd(16'h1011);
      cmd(16'h7000);
      lv(8'h66);
      cmd(16'h8177);
      rb(16'h3101, 8'h77);
      $display("test memory done");
      cmd(16'h9081);
      lv(8'hff);
      cmd(16'h9080);
      lv(8'h66);
      cmd(16'h9001);
      lv(8'h00);
      cmd(16'h9000);
      lv(8'h66);
      cmd(16'hc001);
      cmd(16'h1012);
      lv(8'h12);
      host.rd(`WCD_OFF_STAT, d, r);
      chk(d & 32'h4, 32'h4);
      cmd(16'hc000);
      chk(32'(shutdown_active), 32'h0);
      $display("test scale and shutdown done");
      cmd(16'hd004);
      chk(32'(linear_mode_active), 32'h1);
      rb(16'h3002, 8'h04);
      cmd(16'hd000);
      chk(32'(linear_mode_active), 32'h0);
      cmd(16'h2099);
      lv(8'h12);
      load_wiper_strobe_n <= 1'b0;
      repeat (2) @(posedge aclk);
      load_wiper_strobe_n <= 1'b1;
      repeat (3) @(posedge aclk);
      lv(8'h99);
      $display("test mode and pin load done");
      host.wr(`WCD_OFF_CMD, 16'h1001, 4'h1, r);
      chk(32'(r), 32'(`WCD_RESP_SLVERR));
      host.rd(8'h20, d, r);
      chk({d[7:0], 22'h0, r}, {30'h0, `WCD_RESP_DECERR});
      cmd(16'hb000);
      host.wr(`WCD_OFF_CMD, 16'h1001, 4'hf, r);
      chk(32'(r), 32'(`WCD_RESP_SLVERR));
      for (int i = 0; i < 40; i++) begin
         @(posedge aclk);
         host.rd(`WCD_OFF_STAT, d, r);
         if (d[`WCD_ST_BUSY] === 1'b0)
            break;
      end
      repeat (2) @(posedge aclk);
      chk(32'(d[`WCD_ST_BUSY]), 32'h0);
      lv(8'h66);
      $display("test refusals and soft reset done");
      rst(1'b1);
      chk(32'(linear_mode_active), 32'h1);
      chk(32'({wiper_wb_level, wiper_aw_level}), 32'h8080);
      cmd(16'h1455);
      chk(32'({wiper_wb_level, wiper_aw_level}), 32'h8055);
      $display("test pin at reset done");
      end_sim;
   end
   initial begin
      repeat (20000) @(posedge aclk);
      $display("[FAIL] %0t watchdog expired", $time);
      err_total++;
      end_sim;
   end
endmodule // test_wiper_command_decoder

// [testbench/wcd_host.sv]
// axi4-lite master standing in for the host controller
// assumes its tasks are entered just after a rising aclk edge
`timescale 1ns/100ps
module wcd_host (
   input wire logic aclk,
   output logic [7:0] s_axi_awaddr,
   output logic s_axi_awvalid,
   input wire logic s_axi_awready,
   output logic [31:0] s_axi_wdata,
   output logic [3:0] s_axi_wstrb,
   output logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   output logic s_axi_bready,
   output logic [7:0] s_axi_araddr,
   output logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   output logic s_axi_rready
);
   initial begin
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
      {s_axi_arvalid, s_axi_rready} = 2'h0;
   end
   // released payloads are inverted so stale ones fail
   task automatic wr(input logic [7:0] a, input logic [15:0] w,
         input logic [3:0] s, output logic [1:0] r);
      bit done = 0;
      s_axi_awaddr <= a;
      s_axi_wdata <= {16'h0000, w};
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!done) begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) begin
            s_axi_awvalid <= 1'b0;
            s_axi_awaddr <= ~a;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            s_axi_wvalid <= 1'b0;
            s_axi_wdata <= ~s_axi_wdata;
         end
         if (s_axi_bvalid) begin
            r = s_axi_bresp;
            s_axi_bready <= 1'b0;
            done = 1;
         end
      end
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d,
         output logic [1:0] r);
      bit done = 0;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      while (!done) begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arvalid <= 1'b0;
            s_axi_araddr <= ~a;
         end
         if (s_axi_rvalid) begin
            d = s_axi_rdata;
            r = s_axi_rresp;
            s_axi_rready <= 1'b0;
            done = 1;
         end
      end
   endtask
endmodule // wcd_host

// [testbench/wcd_monitor.sv]
// checker for the wiper command decoder, watching the top ports only
// assumes one aclk domain and a bind onto every wcd_top instance
`timescale 1ns/100ps
`include "wcd_cfg.svh"
module wcd_monitor #(parameter int W = 8, parameter int ADDR_W = 8) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic independent_strings_pin,
   input wire logic [W-1:0] wiper_wb_level,
   input wire logic shutdown_active,
   input wire logic linear_mode_active
);
   logic [15:0] cmd_q;
   logic [ADDR_W-1:0] wa_q;
   logic [ADDR_W-1:0] ra_q;
   // address and word arrive apart, so keep both
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cmd_q <= 16'h0000;
         wa_q <= '0;
         ra_q <= '0;
      end else begin
         if (s_axi_wvalid && s_axi_wready)
            cmd_q <= s_axi_wdata[15:0];
         if (s_axi_awvalid && s_axi_awready)
            wa_q <= s_axi_awaddr;
         if (s_axi_arvalid && s_axi_arready)
            ra_q <= s_axi_araddr;
      end
   end
   wire cmd_ok = wa_q == `WCD_OFF_CMD && s_axi_bresp == `WCD_RESP_OKAY;
   wire [3:0] code_w = cmd_q[15:12];
   wire one_w = !cmd_q[11] && !cmd_q[10];
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   property p_shdn_set;
      $rose(s_axi_bvalid) && cmd_ok && code_w == 4'hc
         |-> shutdown_active == cmd_q[0];
   endproperty
   a_shdn_set: assert property (p_shdn_set)
      else $error("shutdown flag wrong");
   property p_shdn_cause;
      $changed(shutdown_active)
         |-> $rose(s_axi_bvalid) && cmd_ok && code_w == 4'hc;
   endproperty
   a_shdn_cause: assert property (p_shdn_cause)
      else $error("shutdown flag moved alone");
   property p_top;
      $rose(s_axi_bvalid) && cmd_ok && code_w == 4'h9 && cmd_q[7]
         && cmd_q[0] |=> wiper_wb_level == {W{1'b1}};
   endproperty
   a_top: assert property (p_top)
      else $error("top scale wrong");
   property p_bot;
      $rose(s_axi_bvalid) && cmd_ok && code_w == 4'h9 && !cmd_q[7]
         && cmd_q[0] |=> wiper_wb_level == {W{1'b0}};
   endproperty
   a_bot: assert property (p_bot)
      else $error("bottom scale wrong");
   property p_wr_wiper;
      $rose(s_axi_bvalid) && cmd_ok && code_w == 4'h1 && one_w
         |-> ##[1:2] wiper_wb_level == cmd_q[W-1:0];
   endproperty
   a_wr_wiper: assert property (p_wr_wiper)
      else $error("wiper write lost");
   property p_lin_init;
      $rose(aresetn) && independent_strings_pin
         |-> ##[1:2] linear_mode_active;
   endproperty
   a_lin_init: assert property (p_lin_init)
      else $error("pin mode lost");
   property p_rd_stat;
      $rose(s_axi_rvalid) && ra_q == `WCD_OFF_STAT
         |-> s_axi_rdata[2:1] == {shutdown_active, linear_mode_active};
   endproperty
   a_rd_stat: assert property (p_rd_stat)
      else $error("status word wrong");
   property p_nop;
      $rose(s_axi_bvalid) && cmd_ok && code_w == 4'h0
         |=> $stable(wiper_wb_level) [*2];
   endproperty
   a_nop: assert property (p_nop)
      else $error("nop moved wiper");
endmodule // wcd_monitor

bind wcd_top wcd_monitor #(.W(W), .ADDR_W(ADDR_W)) u_mon (.*);
